// ==== core/asi_core.sv ====
// file: execution slice for sleep entry, subtract, nibble swap and exclusive-or
//
// Notes on behaviour
// [RULE_01] sleep clears watchdog counter and its prescaler to zero
// [RULE_02] sleep sets the active-low timeout flag to one
// [RULE_03] sleep clears the active-low power-down flag to zero
// [RULE_04] after updates, sleep halts the core; instruction takes one cycle
// [RULE_05] register subtract: reg minus accumulator, updates c, dc, z, one cycle
// [RULE_06] destination bit 0 writes accumulator, 1 writes addressed register
// [RULE_07] immediate subtract: imm minus accumulator into accumulator, c dc z
// [RULE_08] swap exchanges nibbles, flags untouched, one cycle
// [RULE_09] register xor: acc xor reg to destination, only zero flag
// [RULE_10] immediate xor: acc xor imm into accumulator, only zero flag
// [RULE_11] z on zero result; c and dc mean no borrow out of bit 7, bit 3
`timescale 1ns/100ps
`default_nettype none
module asi_core
    import asi_pkg::*;
#(
    parameter int DW = ASI_DATA_W,
    parameter int AW = ASI_ADDR_W
) (
    input wire logic clk_i, // 200 MHz core clock
    input wire logic rst_i, // async reset, active high
    input wire logic issue_i, // decoder presents an instruction
    input wire asi_op_e op_i, // operation select
    input wire logic [AW-1:0] reg_addr_i, // register operand address
    input wire logic dest_i, // destination bit
    input wire logic [DW-1:0] imm_i, // immediate operand
    input wire logic wake_i, // wake-up request from sleep
    output logic issue_ready_o, // core accepts an instruction
    output logic [DW-1:0] accumulator_o, // accumulator
    output logic carry_flag_o, // carry / not borrow
    output logic digit_carry_flag_o, // digit carry / not borrow from bit 3
    output logic zero_flag_o, // zero flag
    output logic timeout_flag_n_o, // active-low timeout status
    output logic powerdown_flag_n_o, // active-low power-down status
    output logic [DW-1:0] watchdog_counter_o, // watchdog counter
    output logic [DW-1:0] watchdog_prescaler_o, // watchdog prescaler
    output logic sleeping_o, // core halted in sleep
    output logic done_o, // instruction retired (pulse)
    output logic [DW-1:0] result_o // last result value
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (DW != 2 * ASI_NIB_W)
        $error("asi_core: data width must be two nibbles");
    if (AW < 1 || AW > 8)
        $error("asi_core: address width out of range");

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        asi_state_e st;
        logic pend;
        asi_op_e op;
        logic [AW-1:0] addr;
        logic dest;
        logic [DW-1:0] imm;
        logic [DW-1:0] acc;
        logic c;
        logic dc;
        logic z;
        logic to_n;
        logic pd_n;
        logic [DW-1:0] wdt;
        logic [DW-1:0] psc;
        logic done;
        logic [DW-1:0] res;
    } asi_state_s;

    asi_state_s s_q, s_d;
    logic [DW-1:0] rf_rdata;
    logic rf_we;
    logic [AW-1:0] rf_waddr;
    logic [DW-1:0] rf_wdata;
    logic [DW:0] diff;
    logic [ASI_NIB_W:0] ndiff;
    logic [DW-1:0] opnd;
    logic [DW-1:0] res;
    logic take;

    // register read takes one cycle, so a register op is latched and executed
    // the following cycle; issue_ready drops meanwhile to hold back the decoder
    asi_regfile #(.DW(DW), .AW(AW)) i_asi_regfile (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raddr_i(reg_addr_i),
        .rdata_o(rf_rdata),
        .we_i(rf_we),
        .waddr_i(rf_waddr),
        .wdata_i(rf_wdata)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        rf_we = 1'b0;
        rf_waddr = s_q.addr;
        rf_wdata = ASI_ZERO_BYTE;
        res = ASI_ZERO_BYTE;
        take = (s_q.st == ASI_ST_RUN) && !s_q.pend && issue_i;
        opnd = (s_q.op == ASI_OP_SUB_IMM || s_q.op == ASI_OP_XOR_IMM) ? s_q.imm : rf_rdata;
        // two's complement subtract: operand minus accumulator
        diff = {1'b0, opnd} + {1'b0, ~s_q.acc} + {{DW{1'b0}}, 1'b1}; // [RULE_05] [RULE_07]
        ndiff = {1'b0, opnd[ASI_NIB_W-1:0]} + {1'b0, ~s_q.acc[ASI_NIB_W-1:0]}
              + {{ASI_NIB_W{1'b0}}, 1'b1};
        if (take)
        begin
            s_d.op = op_i;
            s_d.addr = reg_addr_i;
            s_d.dest = dest_i;
            s_d.imm = imm_i;
            s_d.pend = (op_i != ASI_OP_NOP);
        end
        if (s_q.pend)
        begin
            s_d.pend = 1'b0;
            s_d.done = 1'b1;
            case (s_q.op)
                ASI_OP_SLEEP:
                begin
                    s_d.wdt = ASI_WDT_CLEAR; // [RULE_01]
                    s_d.psc = ASI_PSC_CLEAR; // [RULE_01]
                    s_d.to_n = ASI_TO_SLEEP; // [RULE_02]
                    s_d.pd_n = ASI_PD_SLEEP; // [RULE_03]
                    s_d.st = ASI_ST_SLEEP; // [RULE_04]
                end
                ASI_OP_SUB_REG, ASI_OP_SUB_IMM:
                begin
                    res = diff[DW-1:0];
                    s_d.c = diff[DW]; // [RULE_11]
                    s_d.dc = ndiff[ASI_NIB_W]; // [RULE_11]
                    s_d.z = (res == ASI_ZERO_BYTE); // [RULE_11]
                end
                ASI_OP_SWAP:
                    res = {opnd[ASI_NIB_W-1:0], opnd[DW-1:ASI_NIB_W]}; // [RULE_08]
                ASI_OP_XOR_REG, ASI_OP_XOR_IMM:
                begin
                    res = s_q.acc ^ opnd; // [RULE_09] [RULE_10]
                    s_d.z = (res == ASI_ZERO_BYTE); // [RULE_09] [RULE_10]
                end
                default:
                    s_d.done = 1'b0;
            endcase
            if (s_q.op != ASI_OP_SLEEP && s_q.op != ASI_OP_NOP)
            begin
                s_d.res = res;
                // immediate forms always land in the accumulator
                if ((s_q.op == ASI_OP_SUB_REG || s_q.op == ASI_OP_SWAP
                     || s_q.op == ASI_OP_XOR_REG) && s_q.dest == ASI_DEST_REG)
                begin
                    rf_we = 1'b1; // [RULE_06]
                    rf_wdata = res;
                end
                else
                begin
                    s_d.acc = res; // [RULE_06] [RULE_07]
                end
            end
        end
        if (s_q.st == ASI_ST_SLEEP && wake_i)
        begin
            s_d.st = ASI_ST_RUN;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_q <= '{st: ASI_ST_RUN, pend: 1'b0, op: ASI_OP_NOP, addr: '0,
                     dest: ASI_DEST_ACC, imm: ASI_ZERO_BYTE, acc: ASI_ACC_RESET,
                     c: 1'b0, dc: 1'b0, z: 1'b0, to_n: ASI_FLAG_RESET,
                     pd_n: ASI_FLAG_RESET, wdt: ASI_WDT_CLEAR, psc: ASI_PSC_CLEAR,
                     done: 1'b0, res: ASI_ZERO_BYTE};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign issue_ready_o = (s_q.st == ASI_ST_RUN) && !s_q.pend;
    assign accumulator_o = s_q.acc;
    assign carry_flag_o = s_q.c;
    assign digit_carry_flag_o = s_q.dc;
    assign zero_flag_o = s_q.z;
    assign timeout_flag_n_o = s_q.to_n;
    assign powerdown_flag_n_o = s_q.pd_n;
    assign watchdog_counter_o = s_q.wdt;
    assign watchdog_prescaler_o = s_q.psc;
    assign sleeping_o = (s_q.st == ASI_ST_SLEEP);
    assign done_o = s_q.done;
    assign result_o = s_q.res;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_sleep_wdt_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_01]
        $rose(sleeping_o) |-> watchdog_counter_o == ASI_WDT_CLEAR
            && watchdog_prescaler_o == ASI_PSC_CLEAR)
        else $error("watchdog not cleared on sleep");
    a_sleep_to_set: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_02]
        $rose(sleeping_o) |-> timeout_flag_n_o)
        else $error("timeout flag not set on sleep");
    a_sleep_pd_clr: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_03]
        $rose(sleeping_o) |-> !powerdown_flag_n_o)
        else $error("power-down flag not cleared on sleep");
    a_sleep_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_04]
        issue_i && issue_ready_o && op_i == ASI_OP_SLEEP |=> ##1 sleeping_o && done_o)
        else $error("sleep did not halt after one cycle");
    a_sub_value: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_07]
        issue_i && issue_ready_o && op_i == ASI_OP_SUB_IMM |=>
            ##1 accumulator_o == DW'($past(imm_i, 2) - $past(accumulator_o, 2)))
        else $error("immediate subtract result wrong");
    a_sub_carry: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_11]
        issue_i && issue_ready_o && op_i == ASI_OP_SUB_IMM |=>
            ##1 carry_flag_o == ($past(imm_i, 2) >= $past(accumulator_o, 2)))
        else $error("carry not equal to no-borrow");
    a_xor_imm_val: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_10]
        issue_i && issue_ready_o && op_i == ASI_OP_XOR_IMM |=>
            ##1 accumulator_o == ($past(imm_i, 2) ^ $past(accumulator_o, 2))
            && zero_flag_o == (accumulator_o == ASI_ZERO_BYTE)
            && carry_flag_o == $past(carry_flag_o))
        else $error("immediate xor wrong or touched carry");
    a_swap_flags: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_08]
        done_o && $past(s_q.op) == ASI_OP_SWAP |-> $stable(zero_flag_o)
            && $stable(carry_flag_o) && $stable(digit_carry_flag_o))
        else $error("swap changed flags");
    a_dest_reg: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_06]
        rf_we |=> $stable(accumulator_o))
        else $error("register destination also wrote accumulator");

    // ------------------------------------------------------------
    // assertions on the execute cycle
    // ------------------------------------------------------------
    // these fire in the cycle in which the latched op executes, so the operand
    // on the regfile read port is the one the result must be built from
    a_sub_reg_val: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_05]
        s_q.pend && s_q.op == ASI_OP_SUB_REG |=>
            result_o == DW'($past(rf_rdata) - $past(s_q.acc))
            && carry_flag_o == ($past(rf_rdata) >= $past(s_q.acc)))
        else $error("register subtract result or carry wrong");
    a_sub_dcarry: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_11]
        s_q.pend && (s_q.op == ASI_OP_SUB_REG || s_q.op == ASI_OP_SUB_IMM) |=>
            digit_carry_flag_o == ($past(opnd[ASI_NIB_W-1:0])
                >= $past(s_q.acc[ASI_NIB_W-1:0]))
            && zero_flag_o == (result_o == ASI_ZERO_BYTE))
        else $error("subtract digit carry or zero flag wrong");
    a_swap_value: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_08]
        s_q.pend && s_q.op == ASI_OP_SWAP |=>
            result_o == {$past(rf_rdata[ASI_NIB_W-1:0]), $past(rf_rdata[DW-1:ASI_NIB_W])})
        else $error("nibble swap result wrong");
    a_xor_reg_val: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_09]
        s_q.pend && s_q.op == ASI_OP_XOR_REG |=>
            result_o == ($past(rf_rdata) ^ $past(s_q.acc))
            && zero_flag_o == (result_o == ASI_ZERO_BYTE)
            && $stable(carry_flag_o) && $stable(digit_carry_flag_o))
        else $error("register xor result wrong or touched carry");
    a_dest_acc: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_06]
        s_q.pend && s_q.dest == ASI_DEST_ACC && (s_q.op == ASI_OP_SUB_REG
            || s_q.op == ASI_OP_SWAP || s_q.op == ASI_OP_XOR_REG) |=>
            accumulator_o == result_o)
        else $error("accumulator destination not written");
    a_dest_reg_wr: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_06]
        s_q.pend && s_q.dest == ASI_DEST_REG && (s_q.op == ASI_OP_SUB_REG
            || s_q.op == ASI_OP_SWAP || s_q.op == ASI_OP_XOR_REG) |->
            rf_we && rf_waddr == s_q.addr)
        else $error("register destination not written back");
    a_imm_to_acc: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_07]
        s_q.pend && (s_q.op == ASI_OP_SUB_IMM || s_q.op == ASI_OP_XOR_IMM) |->
            !rf_we ##1 accumulator_o == result_o)
        else $error("immediate op missed the accumulator");

    // ------------------------------------------------------------
    // assertions on handshake and sleep
    // ------------------------------------------------------------
    // the decoder relies on the ready gap: a second op taken during the
    // register read would overwrite the latched operands
    a_ready_gap: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_04]
        issue_i && issue_ready_o && op_i != ASI_OP_NOP |=> !issue_ready_o)
        else $error("ready stayed high after an instruction was taken");
    a_done_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_04]
        done_o |=> !done_o)
        else $error("done held for more than one cycle");
    a_sleep_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_04]
        sleeping_o && !wake_i |=> sleeping_o && !issue_ready_o && !done_o)
        else $error("core left sleep without a wake request");
    a_sleep_keep: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_04]
        sleeping_o |=> $stable(accumulator_o) && $stable(result_o))
        else $error("state changed while asleep");
    // wake or reset is the only way out; the wake source sits outside this slice
    a_wake_run: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_04]
        sleeping_o && wake_i |=> !sleeping_o && issue_ready_o)
        else $error("wake request did not resume the core");
endmodule // asi_core
`default_nettype wire

// ==== core/asi_pkg.sv ====
// package: constants and types for the sleep/subtract/swap/xor execution slice
package asi_pkg;
    localparam int ASI_DATA_W = 8;
    localparam int ASI_ADDR_W = 6;
    localparam int ASI_NREGS = 64;
    localparam logic [7:0] ASI_ZERO_BYTE = 8'h00;
    localparam logic [7:0] ASI_WDT_CLEAR = 8'h00;
    localparam logic [7:0] ASI_PSC_CLEAR = 8'h00;
    localparam logic [7:0] ASI_ACC_RESET = 8'h00;
    localparam logic ASI_DEST_ACC = 1'b0;
    localparam logic ASI_DEST_REG = 1'b1;
    localparam logic ASI_TO_SLEEP = 1'b1;
    localparam logic ASI_PD_SLEEP = 1'b0;
    localparam logic ASI_FLAG_RESET = 1'b1;
    localparam int ASI_NIB_W = 4;

    typedef enum logic [2:0] {
        ASI_OP_NOP = 3'h0,
        ASI_OP_SLEEP = 3'h1,
        ASI_OP_SUB_REG = 3'h2,
        ASI_OP_SUB_IMM = 3'h3,
        ASI_OP_SWAP = 3'h4,
        ASI_OP_XOR_REG = 3'h5,
        ASI_OP_XOR_IMM = 3'h6
    } asi_op_e;

    typedef enum logic [0:0] {
        ASI_ST_RUN = 1'h0,
        ASI_ST_SLEEP = 1'h1
    } asi_state_e;
endpackage : asi_pkg

// ==== core/asi_regfile.sv ====
// file: 64-entry data register memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module asi_regfile
    import asi_pkg::*;
#(
    parameter int DW = ASI_DATA_W,
    parameter int AW = ASI_ADDR_W
) (
    input wire logic clk_i, // core clock
    input wire logic rst_i, // async reset, active high
    input wire logic [AW-1:0] raddr_i, // read address
    output logic [DW-1:0] rdata_o, // read data, registered
    input wire logic we_i, // write strobe
    input wire logic [AW-1:0] waddr_i, // write address
    input wire logic [DW-1:0] wdata_i // write data
);
    logic [DW-1:0] mem_q [2**AW];

    // cleared on reset so register operands are defined from the first instruction;
    // costs a reset on every entry, so the array will not map onto a plain ram macro
    for (genvar i = 0; i < 2**AW; i++)
    begin : g_entry
        always_ff @(posedge clk_i or posedge rst_i)
        begin
            if (rst_i)
            begin
                mem_q[i] <= '0;
            end
            else if (we_i && waddr_i == AW'(i))
            begin
                mem_q[i] <= wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_o <= '0;
        end
        else
        begin
            rdata_o <= mem_q[raddr_i];
        end
    end
endmodule // asi_regfile
`default_nettype wire

// ==== tb/tb_top.sv ====
// testbench: self-checking bench for the sleep, subtract, swap and xor execution slice
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import asi_pkg::*;
;
    logic clk_i, rst_i, issue_i, dest_i, wake_i;
    asi_op_e op_i;
    logic [5:0] reg_addr_i;
    logic [7:0] imm_i;
    logic rdy, c, dc, z, to_n, pd_n, slp, done;
    logic [7:0] acc, wdt, psc, res;
    int miscompares = 0;
    int cmp_count = 0;
    // model state; a negative expectation skips that comparison
    int m_acc, m_c, m_dc, m_z, m_res, m_to, m_pd, m_sl;
    int m_rf[ASI_NREGS];
    asi_op_e ops[5] = '{ASI_OP_SUB_IMM, ASI_OP_XOR_IMM, ASI_OP_SUB_REG, ASI_OP_SWAP,
        ASI_OP_XOR_REG};
    asi_core i_asi_core (.clk_i(clk_i), .rst_i(rst_i), .issue_i(issue_i), .op_i(op_i),
        .reg_addr_i(reg_addr_i), .dest_i(dest_i), .imm_i(imm_i), .wake_i(wake_i),
        .issue_ready_o(rdy), .accumulator_o(acc), .carry_flag_o(c),
        .digit_carry_flag_o(dc), .zero_flag_o(z), .timeout_flag_n_o(to_n),
        .powerdown_flag_n_o(pd_n), .watchdog_counter_o(wdt), .watchdog_prescaler_o(psc),
        .sleeping_o(slp), .done_o(done), .result_o(res));
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // --------------------------------------------------------------
    // checking helpers
    // --------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input int exp, input string what);
        if (exp >= 0)
        begin
            cmp_count++;
            if (got !== exp[7:0])
            begin
                miscompares++;
                $display("Error at %0t: %s got %h expected %h", $time, what, got, exp[7:0]);
            end
        end
    endtask
    task automatic chk_all();
        chk(acc, m_acc, "acc");
        chk({7'h00, c}, m_c, "carry");
        chk({7'h00, dc}, m_dc, "digit carry");
        chk({7'h00, z}, m_z, "zero");
        chk(res, m_res, "result");
        chk({7'h00, to_n}, m_to, "timeout flag");
        chk({7'h00, pd_n}, m_pd, "powerdown flag");
        chk(wdt, 0, "watchdog");
        chk(psc, 0, "prescaler");
        chk({7'h00, slp}, m_sl, "sleeping");
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        m_acc = 0;
        m_c = 0;
        m_dc = 0;
        m_z = 0;
        m_res = 0;
        m_to = 1;
        m_pd = 1;
        m_sl = 0;
        foreach (m_rf[i])
            m_rf[i] = 0;
        chk_all();
    endtask
    task automatic do_op(input asi_op_e op, input logic [5:0] a, input logic d,
        input logic [7:0] im);
        int n;
        int v;
        int src;
        v = int'(im);
        src = (op == ASI_OP_SUB_IMM || op == ASI_OP_XOR_IMM) ? v : m_rf[a];
        @(posedge clk_i);
        op_i <= op;
        reg_addr_i <= a;
        dest_i <= d;
        imm_i <= im;
        issue_i <= 1'b1;
        #1;
        n = 0;
        while (rdy !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        // ready was high through this cycle, so the coming edge takes the request
        @(posedge clk_i);
        issue_i <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk_i);
            #1;
            n++;
        end while (done !== 1'b1 && n < 10);
        chk({7'h00, done}, 1, "done pulse");
        case (op)
            ASI_OP_SUB_IMM, ASI_OP_SUB_REG:
            begin
                m_res = (src - m_acc) & 255;
                m_c = int'(src >= m_acc);
                m_dc = int'((src & 15) >= (m_acc & 15));
                m_z = int'(m_res == 0);
            end
            ASI_OP_XOR_IMM, ASI_OP_XOR_REG:
            begin
                m_res = src ^ m_acc;
                m_z = int'(m_res == 0);
            end
            ASI_OP_SWAP:
                m_res = ((src & 15) << 4) | (src >> 4);
            ASI_OP_SLEEP:
            begin
                m_to = 1;
                m_pd = 0;
                m_sl = 1;
            end
            default:
                ;
        endcase
        // register forms follow the destination bit, immediate forms go to the accumulator
        if (op != ASI_OP_SLEEP && op != ASI_OP_NOP)
        begin
            if (d == ASI_DEST_REG && op != ASI_OP_SUB_IMM && op != ASI_OP_XOR_IMM)
                m_rf[a] = m_res;
            else
                m_acc = m_res;
        end
        chk_all();
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        $display("Error at %0t: run timed out", $time);
        complete_run();
    end
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        int k;
        asi_op_e op;
        rst_i = 1'b1;
        issue_i = 1'b0;
        op_i = ASI_OP_NOP;
        reg_addr_i = 6'h00;
        dest_i = 1'b0;
        imm_i = 8'h00;
        wake_i = 1'b0;
        k = $urandom(39764);
        do_reset();
        $display("test reset done");
        do_op(ASI_OP_SUB_IMM, 6'h00, 1'b0, 8'h00);
        do_op(ASI_OP_XOR_IMM, 6'h00, 1'b0, 8'h01);
        do_op(ASI_OP_SUB_IMM, 6'h00, 1'b0, 8'h00);
        do_op(ASI_OP_XOR_IMM, 6'h00, 1'b0, 8'hFF);
        do_op(ASI_OP_SUB_IMM, 6'h00, 1'b0, 8'h10);
        do_op(ASI_OP_XOR_IMM, 6'h00, 1'b0, 8'h0F);
        $display("test immediate boundaries done");
        // random operands and destinations; the model mirrors every register
        for (k = 0; k < 60; k++)
        begin
            op = ops[$urandom % 5];
            do_op(op, 6'($urandom), 1'($urandom), 8'($urandom));
        end
        do_op(ASI_OP_SWAP, 6'h3F, ASI_DEST_REG, 8'h00);
        $display("test random mix done");
        do_op(ASI_OP_SLEEP, 6'h00, 1'b0, 8'h00);
        @(posedge clk_i);
        op_i <= ASI_OP_XOR_IMM;
        imm_i <= 8'h5A;
        issue_i <= 1'b1;
        for (k = 0; k < 6; k++)
        begin
            @(posedge clk_i);
            #1;
            chk({7'h00, done}, 0, "done while asleep");
            chk({7'h00, rdy}, 0, "ready while asleep");
        end
        chk(acc, m_acc, "acc while asleep");
        @(posedge clk_i);
        issue_i <= 1'b0;
        wake_i <= 1'b1;
        @(posedge clk_i);
        wake_i <= 1'b0;
        m_sl = 0;
        do_op(ASI_OP_XOR_IMM, 6'h00, 1'b0, 8'h3C);
        $display("test sleep done");
        do_op(ASI_OP_SUB_IMM, 6'h00, 1'b0, 8'h80);
        do_op(ASI_OP_SWAP, 6'h01, ASI_DEST_ACC, 8'h00);
        do_op(ASI_OP_XOR_REG, 6'h02, ASI_DEST_ACC, 8'h00);
        do_op(ASI_OP_SUB_REG, 6'h03, ASI_DEST_ACC, 8'h00);
        $display("test accumulator destination done");
        @(posedge clk_i);
        do_reset();
        do_op(ASI_OP_XOR_REG, 6'($urandom), ASI_DEST_ACC, 8'h00);
        $display("test second reset done");
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
